// File: rtl/tcs_pkg.sv
// shared constants and types for the triggered capture sequencer
package tcs_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int US_CYCLES = CLK_HZ / 1000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int TIMEOUT_MAX_MS = 655350;
  localparam int CODE_MIN = 1;
  localparam int CODE_MAX = 400;
  localparam int POOL_DEPTH = 254;
  localparam int SLOT_W = 8;
  localparam int CNT_W = 16;
  localparam int CODE_W = 9;
  localparam int TMR_W = 32;
  localparam int TO_W = 20;
  localparam logic [7:0] TRIG_CHAR_RESET = 8'h20;
  localparam logic [CNT_W-1:0] CNT_UNLIMITED = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 8'hfd;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 8'h00;

  typedef enum logic { TCS_MODE_CONT, TCS_MODE_TIMED } tcs_mode_t;
  typedef enum logic [2:0] {
    TCS_IDLE, TCS_DELAY, TCS_BURST, TCS_CONT, TCS_TIMED
  } tcs_state_t;
endpackage

// File: rtl/tcs_slot_ram.sv
// image buffer pool: per-slot capture tag memory, registered read
`timescale 1ns/1ps
module tcs_slot_ram
  import tcs_pkg::*;
(
  // clock
  input  wire logic              clk_sys,
  // write side
  input  wire logic              wr_en,
  input  wire logic [SLOT_W-1:0] wr_addr,
  input  wire logic [CNT_W-1:0]  wr_data,
  // read side
  input  wire logic [SLOT_W-1:0] rd_addr,
  output      logic [CNT_W-1:0]  rd_data
);
  logic [CNT_W-1:0] mem [POOL_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// File: rtl/tcs_sequencer.sv
// read-cycle sequencer for triggered continuous and timed rapid capture
`timescale 1ns/1ps
module tcs_sequencer
  import tcs_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // configuration
  input  wire logic              cfg_mode,
  input  wire logic [7:0]        cfg_trig_char,
  input  wire logic              cfg_edge_rise,
  input  wire logic [TMR_W-1:0]  cfg_delay_us,
  input  wire logic [TMR_W-1:0]  cfg_gap_us,
  input  wire logic [CNT_W-1:0]  cfg_burst,
  input  wire logic [CNT_W-1:0]  cfg_captures,
  input  wire logic [CODE_W-1:0] cfg_codes,
  input  wire logic [TO_W-1:0]   cfg_timeout_ms,
  // trigger sources
  input  wire logic              ser_valid,
  input  wire logic [7:0]        ser_char,
  input  wire logic              trig_in,
  // camera
  output      logic              cap_start,
  output      logic [SLOT_W-1:0] cap_slot,
  input  wire logic              cap_done,
  // decoder
  output      logic              dec_start,
  output      logic [SLOT_W-1:0] dec_slot,
  output      logic [CNT_W-1:0]  dec_tag,
  input  wire logic              dec_done,
  input  wire logic [CODE_W-1:0] dec_found,
  // cycle result
  output      logic              cyc_busy,
  output      logic              cyc_end,
  output      logic              cyc_pass,
  output      logic [CODE_W-1:0] cyc_found
);
  function automatic logic [TMR_W-1:0] us_to_cyc(logic [TMR_W-1:0] us);
    us_to_cyc = TMR_W'(us * US_CYCLES);
  endfunction

  function automatic logic [SLOT_W-1:0] slot_inc(logic [SLOT_W-1:0] s);
    slot_inc = (s == SLOT_LAST) ? SLOT_ZERO : SLOT_W'(s + 1'b1);
  endfunction

  tcs_state_t        state_reg;
  logic              trig_d_reg;
  logic              trig;
  logic [TMR_W-1:0]  tmr_reg;
  logic [TMR_W-1:0]  ms_div_reg;
  logic [TO_W-1:0]   ms_cnt_reg;
  logic [CNT_W-1:0]  taken_reg;
  logic [CNT_W-1:0]  done_reg;
  logic [CNT_W-1:0]  proc_reg;
  logic [SLOT_W-1:0] wr_slot_reg;
  logic [SLOT_W-1:0] rd_slot_reg;
  logic              cam_busy_reg;
  logic              dec_busy_reg;
  logic [CODE_W-1:0] need;
  logic [CODE_W:0]   found_sum;
  logic              all_found;
  logic              timed_out;
  logic              count_hit;
  logic              can_cap;
  logic              want_cap;
  logic              want_dec;
  logic              finish;
  logic              active;

  // serial character or physical edge, either polarity
  assign trig = (ser_valid && ser_char == cfg_trig_char) ||
                (cfg_edge_rise ? (trig_in && !trig_d_reg)
                               : (!trig_in && trig_d_reg));

  // a count below the minimum is treated as the minimum
  assign need = (cfg_codes < CODE_W'(CODE_MIN)) ? CODE_W'(CODE_MIN) :
                (cfg_codes > CODE_W'(CODE_MAX)) ? CODE_W'(CODE_MAX) :
                cfg_codes;
  assign all_found = cyc_found >= need;
  // one bit wider so the saturation test sees the carry
  assign found_sum = {1'b0, cyc_found} + {1'b0, dec_found};
  assign timed_out = (cfg_timeout_ms != '0) &&
                     (ms_cnt_reg >= cfg_timeout_ms);
  assign count_hit = (cfg_captures != CNT_UNLIMITED) &&
                     (taken_reg >= cfg_captures);
  assign active = state_reg != TCS_IDLE && state_reg != TCS_DELAY;
  assign can_cap = active && !cam_busy_reg && !count_hit && !cap_done;

  always_comb begin
    want_cap = 1'b0;
    unique case (state_reg)
      TCS_BURST: want_cap = can_cap;
      TCS_CONT:  want_cap = can_cap && dec_done;
      TCS_TIMED: want_cap = can_cap && tmr_reg == TMR_ZERO;
      TCS_IDLE, TCS_DELAY: want_cap = 1'b0;
    endcase
  end

  // decode whatever is buffered while the camera keeps going
  // no fresh decode once the cycle is ending
  assign want_dec = active && !dec_busy_reg && !dec_done && !finish &&
                    done_reg != proc_reg;
  // timed mode needs every capture processed; count must be finite
  assign finish = active && (all_found || timed_out ||
                  (state_reg == TCS_TIMED && count_hit && !cam_busy_reg &&
                   !dec_busy_reg && done_reg == proc_reg));

  assign cap_start = want_cap;
  assign cap_slot  = wr_slot_reg;
  assign cyc_busy  = state_reg != TCS_IDLE;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TCS_IDLE;
    end else if (trig) begin
      state_reg <= TCS_DELAY;
    end else if (finish) begin
      state_reg <= TCS_IDLE;
    end else if (state_reg == TCS_DELAY && tmr_reg == TMR_ZERO) begin
      state_reg <= (cfg_mode == TCS_MODE_TIMED) ? TCS_TIMED
                                                 : TCS_BURST;
    end else if (state_reg == TCS_BURST && (taken_reg >= cfg_burst ||
                 count_hit)) begin
      state_reg <= TCS_CONT;
    end
  end

  // one timer serves the first-capture delay and the capture spacing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= TMR_ZERO;
    end else if (trig) begin
      tmr_reg <= us_to_cyc(cfg_delay_us);
    end else if (want_cap && state_reg == TCS_TIMED) begin
      tmr_reg <= us_to_cyc(cfg_gap_us);
    end else if (tmr_reg != TMR_ZERO) begin
      tmr_reg <= tmr_reg - 1'b1;
    end
  end

  // whole-cycle timeout counts from the trigger in milliseconds
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_reg <= TMR_ZERO;
      ms_cnt_reg <= '0;
    end else if (trig || !cyc_busy) begin
      ms_div_reg <= TMR_ZERO;
      ms_cnt_reg <= '0;
    end else if (ms_div_reg == TMR_W'(MS_CYCLES - 1)) begin
      ms_div_reg <= TMR_ZERO;
      if (!timed_out) begin
        ms_cnt_reg <= ms_cnt_reg + 1'b1;
      end
    end else begin
      ms_div_reg <= ms_div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cam_busy_reg <= 1'b0;
      taken_reg    <= '0;
      done_reg     <= '0;
      wr_slot_reg  <= SLOT_ZERO;
    end else if (trig) begin
      cam_busy_reg <= 1'b0;
      taken_reg    <= '0;
      done_reg     <= '0;
      wr_slot_reg  <= SLOT_ZERO;
    end else begin
      if (want_cap) begin
        cam_busy_reg <= 1'b1;
        taken_reg    <= taken_reg + 1'b1;
      end else if (cap_done && cam_busy_reg) begin
        cam_busy_reg <= 1'b0;
        done_reg     <= done_reg + 1'b1;
        wr_slot_reg  <= slot_inc(wr_slot_reg);
      end
    end
  end

  // decoder issue; slot ram read is one cycle, so tag lags start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_busy_reg <= 1'b0;
      dec_start    <= 1'b0;
      dec_slot     <= SLOT_ZERO;
      proc_reg     <= '0;
      rd_slot_reg  <= SLOT_ZERO;
    end else if (trig) begin
      dec_busy_reg <= 1'b0;
      dec_start    <= 1'b0;
      proc_reg     <= '0;
      rd_slot_reg  <= SLOT_ZERO;
    end else begin
      dec_start <= want_dec;
      if (want_dec) begin
        dec_busy_reg <= 1'b1;
        dec_slot     <= rd_slot_reg;
        rd_slot_reg  <= slot_inc(rd_slot_reg);
        proc_reg     <= proc_reg + 1'b1;
      end else if (dec_done) begin
        dec_busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_found <= '0;
    end else if (trig) begin
      cyc_found <= '0;
    end else if (dec_done && dec_busy_reg && active) begin
      cyc_found <= (found_sum > (CODE_W+1)'(CODE_MAX)) ?
                   CODE_W'(CODE_MAX) : found_sum[CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_end  <= 1'b0;
      cyc_pass <= 1'b0;
    end else begin
      cyc_end  <= (finish && !trig) || (trig && active);
      cyc_pass <= finish && !trig && all_found;
    end
  end

  tcs_slot_ram u_slot_ram (
    .clk_sys (clk_sys),
    .wr_en   (cap_done && cam_busy_reg),
    .wr_addr (wr_slot_reg),
    .wr_data (done_reg),
    .rd_addr (dec_slot),
    .rd_data (dec_tag)
  );
endmodule

// File: tb/tcs_sequencer_sva.sv
// port assertions for the capture sequencer
`timescale 1ns/1ps
module tcs_sequencer_sva
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // triggers and handshakes
  input wire logic              ser_valid,
  input wire logic              trig_in,
  input wire logic              cap_start,
  input wire logic [SLOT_W-1:0] cap_slot,
  input wire logic              cap_done,
  input wire logic              dec_start,
  // result
  input wire logic              cyc_busy,
  input wire logic              cyc_end,
  input wire logic              cyc_pass,
  input wire logic [CODE_W-1:0] cyc_found
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cap_busy; cap_start |-> cyc_busy; endproperty
  a_cap_busy: assert property (p_cap_busy)
    else $error("capture outside a cycle");
  property p_idle; !cyc_busy && !ser_valid && $stable(trig_in) |=> !cyc_busy;
  endproperty
  a_idle: assert property (p_idle)
    else $error("cycle began without a trigger");
  property p_cap_one; cap_start |=> !cap_start; endproperty
  a_cap_one: assert property (p_cap_one)
    else $error("second capture while one pending");
  property p_dec_one; dec_start |=> !dec_start; endproperty
  a_dec_one: assert property (p_dec_one)
    else $error("second decode while one pending");
  property p_done_mute; cap_done |-> !cap_start; endproperty
  a_done_mute: assert property (p_done_mute)
    else $error("capture in the cycle of cap_done");
  property p_slot; cap_start |-> cap_slot <= SLOT_LAST; endproperty
  a_slot: assert property (p_slot)
    else $error("slot beyond the pool");
  property p_pass_end; cyc_pass |-> cyc_end; endproperty
  a_pass_end: assert property (p_pass_end)
    else $error("pass without cycle end");
  property p_found_max; cyc_found <= CODE_MAX; endproperty
  a_found_max: assert property (p_found_max)
    else $error("found count above maximum");

  c_pass: cover property (cyc_pass);
  c_fail: cover property (cyc_end && !cyc_pass);
  c_wrap: cover property (cap_start && cap_slot == SLOT_LAST);
endmodule

bind tcs_sequencer tcs_sequencer_sva u_sva (
  .clk_sys   (clk_sys),
  .rst_n     (rst_n),
  .ser_valid (ser_valid),
  .trig_in   (trig_in),
  .cap_start (cap_start),
  .cap_slot  (cap_slot),
  .cap_done  (cap_done),
  .dec_start (dec_start),
  .cyc_busy  (cyc_busy),
  .cyc_end   (cyc_end),
  .cyc_pass  (cyc_pass),
  .cyc_found (cyc_found)
);

// File: tb/tcs_far_model.sv
// camera and decoder model with adjustable answer delays
`timescale 1ns/1ps
module tcs_far_model
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // requests and pacing
  input wire logic              cap_start,
  input wire logic              dec_start,
  input wire logic [7:0]        cap_lat,
  input wire logic [7:0]        dec_lat,
  input wire logic [CODE_W-1:0] found_each,
  // answers
  output     logic              cap_done,
  output     logic              dec_done,
  output     logic [CODE_W-1:0] dec_found
);
  logic [7:0] cap_cnt;
  logic [7:0] dec_cnt;

  // latencies of 1 or more keep cap_done at least a cycle after start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt   <= 8'h00;
      cap_done  <= 1'b0;
      dec_cnt   <= 8'h00;
      dec_done  <= 1'b0;
      dec_found <= 9'h000;
    end else begin
      cap_done <= (cap_cnt == 8'h01);
      dec_done <= (dec_cnt == 8'h01);
      // count is only meaningful with dec_done, so it wanders otherwise
      dec_found <= (dec_cnt == 8'h01) ? found_each : ~dec_found;
      cap_cnt <= cap_start ? cap_lat : cap_cnt - (cap_cnt != 8'h00);
      dec_cnt <= dec_start ? dec_lat : dec_cnt - (dec_cnt != 8'h00);
    end
  end
endmodule

// File: tb/tcs_sequencer_test.sv
// self-checking bench for the capture sequencer
`timescale 1ns/1ps
module tcs_sequencer_test import tcs_pkg::*;;
  logic clk_sys = 0, rst_n = 0, cfg_mode = 0, cfg_edge_rise = 1;
  logic ser_valid = 0, trig_in = 0, cap_start, cap_done, dec_start;
  logic dec_done, cyc_busy, cyc_end, cyc_pass;
  logic [7:0] cfg_trig_char = 8'h20, ser_char = 8'h00, cap_slot, dec_slot;
  logic [7:0] cap_lat = 8'h03, dec_lat = 8'h05;
  logic [TMR_W-1:0] cfg_delay_us = 0, cfg_gap_us = 0;
  logic [CNT_W-1:0] cfg_burst = 16'h0002, cfg_captures = 0, dec_tag;
  logic [CODE_W-1:0] cfg_codes = 9'h003, found_each = 9'h001;
  logic [CODE_W-1:0] dec_found, cyc_found;
  logic [TO_W-1:0] cfg_timeout_ms = 0;
  int err_count = 0, n_compared = 0, cyc = 0;
  int n_cap, first_cap, last_cap, min_gap, t0, n_dec, max_slot;
  bit tag_due;

  always #12.5 clk_sys = ~clk_sys;
  tcs_sequencer dut (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .cfg_mode       (cfg_mode),
    .cfg_trig_char  (cfg_trig_char),
    .cfg_edge_rise  (cfg_edge_rise),
    .cfg_delay_us   (cfg_delay_us),
    .cfg_gap_us     (cfg_gap_us),
    .cfg_burst      (cfg_burst),
    .cfg_captures   (cfg_captures),
    .cfg_codes      (cfg_codes),
    .cfg_timeout_ms (cfg_timeout_ms),
    .ser_valid      (ser_valid),
    .ser_char       (ser_char),
    .trig_in        (trig_in),
    .cap_start      (cap_start),
    .cap_slot       (cap_slot),
    .cap_done       (cap_done),
    .dec_start      (dec_start),
    .dec_slot       (dec_slot),
    .dec_tag        (dec_tag),
    .dec_done       (dec_done),
    .dec_found      (dec_found),
    .cyc_busy       (cyc_busy),
    .cyc_end        (cyc_end),
    .cyc_pass       (cyc_pass),
    .cyc_found      (cyc_found)
  );
  tcs_far_model far (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .cap_start  (cap_start),
    .dec_start  (dec_start),
    .cap_lat    (cap_lat),
    .dec_lat    (dec_lat),
    .found_each (found_each),
    .cap_done   (cap_done),
    .dec_done   (dec_done),
    .dec_found  (dec_found)
  );

  // tag stands the cycle after dec_start; decodes follow capture order
  always @(negedge clk_sys) begin
    cyc++;
    if (tag_due) begin
      check("decode tag", dec_tag, n_dec);
      n_dec++;
    end
    tag_due = dec_start;
    if (dec_start)
      check("decode slot", dec_slot, n_dec % POOL_DEPTH);
    if (cyc_end) n_dec = 0;
    if (cap_start && cap_slot > max_slot) max_slot = cap_slot;
    if (cap_start) begin
      if (n_cap == 0) first_cap = cyc;
      else if (cyc - last_cap < min_gap) min_gap = cyc - last_cap;
      last_cap = cyc;
      n_cap++;
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // kind 0 serial char, 1 physical edge, 2 wrong serial char
  task automatic fire(int kind);
    @(posedge clk_sys);
    #2;
    ser_valid = (kind != 1);
    ser_char = cfg_trig_char ^ 8'(kind == 2);
    if (kind == 1) trig_in = cfg_edge_rise;
    t0 = cyc;
    n_cap = 0;
    min_gap = 99999;
    @(posedge clk_sys);
    #2;
    ser_valid = 0;
    trig_in = ~cfg_edge_rise;
  endtask

  task automatic wait_end(int limit);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (cyc_end !== 1'b1 && i < limit);
    check("cycle end", cyc_end, 1);
  endtask

  task automatic t_cont;
    fire(2);
    repeat (6) @(negedge clk_sys);
    check("busy on wrong char", cyc_busy, 0);
    @(posedge clk_sys);
    #2;
    cfg_delay_us = 2;
    fire(0);
    wait_end(3000);
    check("pass", cyc_pass, 1);
    check("found", cyc_found, 3);
    check("delay", first_cap - t0 >= 80 && first_cap - t0 <= 86, 1);
    check("burst then paced", n_cap >= 3, 1);
    $display("test cont done");
  endtask

  // all captures decoded with too few codes: ends without pass
  task automatic t_timed(logic [TMR_W-1:0] gap, logic [CNT_W-1:0] n);
    repeat (20) @(posedge clk_sys);
    #2;
    {cfg_mode, cfg_edge_rise, cfg_delay_us} = {2'b10, 32'h0};
    {cfg_gap_us, cfg_captures, cfg_codes} = {gap, n, 9'h190};
    trig_in = 1;
    fire(1);
    wait_end(3000);
    check("timed pass", cyc_pass, 0);
    check("timed found", cyc_found, 32'(n));
    check("capture count", n_cap, 32'(n));
    check("first capture", first_cap - t0 <= 4, 1);
    if (gap == 0) check("burst spacing", min_gap < 40, 1);
    else check("gap spacing", min_gap >= 40, 1);
    $display("test timed done");
  endtask

  task automatic t_retrig;
    repeat (20) @(posedge clk_sys);
    #2;
    {cfg_mode, cfg_edge_rise, cfg_burst} = {2'b01, 16'h0001};
    {cfg_codes, found_each, cfg_timeout_ms} = {9'h000, 9'h000, 20'h1};
    cfg_captures = 16'h0000;
    fire(0);
    repeat (300) @(negedge clk_sys);
    check("still running", cyc_busy, 1);
    fire(0);
    wait_end(10);
    check("retrigger pass", cyc_pass, 0);
    wait_end(42000);
    check("timeout pass", cyc_pass, 0);
    check("timeout span", cyc - t0 >= 39000 && cyc - t0 <= 41000, 1);
    check("slots wrapped", n_cap > POOL_DEPTH, 1);
    check("slot top", max_slot, SLOT_LAST);
    $display("test retrigger and timeout done");
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #2;
    rst_n = 1;
    check("idle after reset", cyc_busy, 0);
    t_cont();
    t_timed(32'h1, 16'h0003);
    t_timed(32'h0, 16'h0004);
    t_retrig();
    end_of_test();
  end

  initial begin
    #1500000;
    err_count++;
    end_of_test();
  end
endmodule
